// *** verilog/mag_event.sv ***
// magnetic control register three, interrupt source flags, detector
// assumes a host register port with one-cycle read and write strobes
`timescale 1ns/1ps
`default_nettype none
`include "mag_event_regs.svh"

module mag_event
	import mag_event_pkg::*;
(
	input wire logic core_clk, // 20 MHz clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [7:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [7:0] reg_rdata, // read data, valid with reg_rvalid
	output logic reg_rvalid, // read answer pulse
	input wire logic sample_valid, // decimated sample strobe
	input wire axis_type raw_x, // decimated x sample
	input wire axis_type raw_y, // decimated y sample
	input wire axis_type raw_z, // decimated z sample
	input wire axis_type off_x, // stored x offset
	input wire axis_type off_y, // stored y offset
	input wire axis_type off_z, // stored z offset
	output axis_type out_x, // x output data
	output axis_type out_y, // y output data
	output axis_type out_z, // z output data
	input wire logic [2:0] odr_sel, // 0 slowest .. 7 fastest rate
	output logic [`OSR_W-1:0] sleep_osr, // oversampling in auto-sleep
	input wire logic ths_event, // threshold detector fired
	input wire logic [2:0] ths_axis, // axes that fired, z y x
	output logic [2:0] ths_ref_load, // threshold references to reload
	input wire logic vecm_en, // vector-magnitude function enable
	input wire logic vecm_latch_en, // vector-magnitude event latch
	input wire logic vecm_initm, // 1 loads references from init values
	input wire logic vecm_updm, // 1 keeps references on event
	input wire axis_type vecm_init_x, // initial x reference
	input wire axis_type vecm_init_y, // initial y reference
	input wire axis_type vecm_init_z, // initial z reference
	input wire ths_type vecm_ths, // magnitude threshold
	input wire cnt_type vecm_cnt // debounce count
);
	logic [7:0] ctrl_three_r;
	logic src_ths_r, src_vecm_r, src_drdy_r;
	logic out_stb_r;
	logic src_read;
	vecm_if vbus();

	assign src_read = reg_rd && reg_addr == `INT_SOURCE_ADDR;

	// ---------------------------------------------------------------
	// register port
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_three_r <= `CTRL_THREE_RST;
		end else if (reg_wr && reg_addr == `CTRL_THREE_ADDR) begin
			ctrl_three_r <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (!reg_rd) begin
				reg_rdata <= reg_rdata;
			end else if (reg_addr == `CTRL_THREE_ADDR) begin
				reg_rdata <= ctrl_three_r;
			end else if (reg_addr == `INT_SOURCE_ADDR) begin
				reg_rdata <= {5'h00, src_ths_r, src_vecm_r, src_drdy_r};
			end else begin
				reg_rdata <= `UNMAPPED_READ;
			end
		end
	end

	// ---------------------------------------------------------------
	// output data with optional offsets
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_x <= '0;
			out_y <= '0;
			out_z <= '0;
			out_stb_r <= 1'b0;
		end else begin
			out_stb_r <= sample_valid;
			if (sample_valid && ctrl_three_r[`OFFSET_BYPASS_BIT]) begin
				out_x <= raw_x;
				out_y <= raw_y;
				out_z <= raw_z;
			end else if (sample_valid) begin
				out_x <= raw_x + off_x;
				out_y <= raw_y + off_y;
				out_z <= raw_z + off_z;
			end
		end
	end

	// ---------------------------------------------------------------
	// auto-sleep oversampling
	// ---------------------------------------------------------------
	function automatic logic [`OSR_W-1:0] osr_of(input logic [2:0] odr,
		input logic [2:0] os);
		int k;
		int l;
		case (odr)
			3'd0: k = 3;
			3'd1: k = 1;
			3'd2: k = 0;
			3'd3: k = -2;
			3'd4: k = -3;
			3'd5: k = -4;
			3'd6: k = -5;
			default: k = -16;
		endcase
		l = ((os == 3'd0) ? 1 : int'(os)) + k;
		if (l < 1) begin
			l = 1;
		end
		return `OSR_W'(1 << l);
	endfunction

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sleep_osr <= `OSR_W'(2);
		end else begin
			sleep_osr <= osr_of(odr_sel,
				ctrl_three_r[`SLEEP_OS_HI:`SLEEP_OS_LO]);
		end
	end

	// ---------------------------------------------------------------
	// threshold reference reload select
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst || !ths_event) begin
			ths_ref_load <= 3'b000;
		end else if (ctrl_three_r[`THS_UPDATE_BIT]) begin
			ths_ref_load <= ths_axis;
		end else begin
			ths_ref_load <= 3'b111;
		end
	end

	// ---------------------------------------------------------------
	// source flags, a set in the clearing cycle wins
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			{src_ths_r, src_vecm_r, src_drdy_r} <= `INT_SOURCE_RST;
		end else begin
			src_ths_r <= ths_event || (src_ths_r && !src_read);
			src_drdy_r <= out_stb_r || (src_drdy_r && !src_read);
			if (vecm_latch_en) begin
				src_vecm_r <= vbus.event_stb
					|| (src_vecm_r && !src_read);
			end else begin
				src_vecm_r <= vbus.active;
			end
		end
	end

	// ---------------------------------------------------------------
	// detector hook-up
	// ---------------------------------------------------------------
	assign vbus.sample_stb = out_stb_r;
	assign vbus.out_x = out_x;
	assign vbus.out_y = out_y;
	assign vbus.out_z = out_z;
	assign vbus.en = vecm_en;
	assign vbus.initm = vecm_initm;
	assign vbus.updm = vecm_updm;
	assign vbus.init_x = vecm_init_x;
	assign vbus.init_y = vecm_init_y;
	assign vbus.init_z = vecm_init_z;
	assign vbus.ths = vecm_ths;
	assign vbus.cnt_lim = vecm_cnt;

	vecm_detect u_det (
		.core_clk(core_clk),
		.rst(rst),
		.bus(vbus)
	);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_bypass_raw_out: assert property (@(posedge core_clk)
		disable iff (rst) sample_valid && ctrl_three_r[`OFFSET_BYPASS_BIT]
		|=> out_x == $past(raw_x))
		else $error("bypass output differs from raw sample");
	a_offset_added: assert property (@(posedge core_clk)
		disable iff (rst) sample_valid && !ctrl_three_r[`OFFSET_BYPASS_BIT]
		|=> out_y == axis_type'($past(raw_y) + $past(off_y)))
		else $error("offset not added to output");
	a_fast_osr_two: assert property (@(posedge core_clk)
		disable iff (rst) odr_sel == 3'd7 |=> sleep_osr == `OSR_W'(2))
		else $error("fastest rate oversampling is not two");
	a_ths_all_axes: assert property (@(posedge core_clk)
		disable iff (rst) ths_event && !ctrl_three_r[`THS_UPDATE_BIT]
		|=> ths_ref_load == 3'b111)
		else $error("not all threshold references reloaded");
	a_ths_one_axis: assert property (@(posedge core_clk)
		disable iff (rst) ths_event && ctrl_three_r[`THS_UPDATE_BIT]
		|=> ths_ref_load == $past(ths_axis))
		else $error("wrong threshold reference reloaded");
	a_ths_flag_set: assert property (@(posedge core_clk)
		disable iff (rst) ths_event |=> src_ths_r)
		else $error("threshold flag not set");
	a_drdy_follows: assert property (@(posedge core_clk)
		disable iff (rst) sample_valid |=> ##1 src_drdy_r)
		else $error("data ready not set after sample");
	a_vecm_latched: assert property (@(posedge core_clk)
		disable iff (rst) src_vecm_r && vecm_latch_en && !src_read
		&& $stable(vecm_latch_en) |=> src_vecm_r || !vecm_latch_en)
		else $error("latched flag dropped without read");
	a_vecm_event_flag: assert property (@(posedge core_clk)
		disable iff (rst) vbus.event_stb && vecm_latch_en |=> src_vecm_r)
		else $error("vector-magnitude flag not set");
	a_src_read_image: assert property (@(posedge core_clk)
		disable iff (rst) src_read |=> reg_rdata[7:3] == 5'h00)
		else $error("upper source bits not zero");
	c_src_read_clear: cover property (@(posedge core_clk)
		src_read && src_drdy_r ##1 !src_drdy_r);
	c_vecm_latched: cover property (@(posedge core_clk)
		vecm_latch_en && src_vecm_r);
endmodule

`default_nettype wire

// *** shared/mag_event_regs.svh ***
// register offsets, field positions, reset values and widths
// assumes inclusion by bare name from the design files
`ifndef MAG_EVENT_REGS_SVH
`define MAG_EVENT_REGS_SVH

`define CTRL_THREE_ADDR 8'h5d
`define INT_SOURCE_ADDR 8'h5e
`define CTRL_THREE_RST 8'h00
`define INT_SOURCE_RST 3'h0
`define UNMAPPED_READ 8'h00

`define OFFSET_BYPASS_BIT 7
`define SLEEP_OS_HI 6
`define SLEEP_OS_LO 4
`define THS_UPDATE_BIT 3

`define SRC_THS_BIT 2
`define SRC_VECM_BIT 1
`define SRC_DRDY_BIT 0

`define AXIS_W 16
`define THS_W 15
`define CNT_W 8
`define OSR_W 11

`endif

// *** shared/mag_event_pkg.sv ***
// types shared by the magnetic event block and its detector
// assumes mag_event_regs.svh is compiled first
`default_nettype none
`include "mag_event_regs.svh"

package mag_event_pkg;
	typedef logic signed [`AXIS_W-1:0] axis_type;
	typedef logic [`THS_W-1:0] ths_type;
	typedef logic [`CNT_W-1:0] cnt_type;
	typedef enum logic {det_off, det_on} det_state_type;
endpackage

`default_nettype wire

// *** shared/vecm_if.sv ***
// carrier between the event block and the vector-magnitude detector
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none

interface vecm_if;
	import mag_event_pkg::*;
	logic sample_stb;
	axis_type out_x;
	axis_type out_y;
	axis_type out_z;
	logic en;
	logic initm;
	logic updm;
	axis_type init_x;
	axis_type init_y;
	axis_type init_z;
	ths_type ths;
	cnt_type cnt_lim;
	logic event_stb;
	logic active;
	modport ctl(output sample_stb, out_x, out_y, out_z, en, initm, updm,
		init_x, init_y, init_z, ths, cnt_lim, input event_stb, active);
	modport det(input sample_stb, out_x, out_y, out_z, en, initm, updm,
		init_x, init_y, init_z, ths, cnt_lim, output event_stb, active);
endinterface

`default_nettype wire

// *** verilog/vecm_detect.sv ***
// vector-magnitude change detector with internal reference vector
// assumes sample_stb pulses once per output data cycle with new output
`timescale 1ns/1ps
`default_nettype none
`include "mag_event_regs.svh"

module vecm_detect
	import mag_event_pkg::*;
(
	input wire logic core_clk, // 20 MHz clock
	input wire logic rst, // synchronous reset, active high
	vecm_if.det bus // detector side of the carrier
);
	det_state_type state_r;
	axis_type ref_x_r, ref_y_r, ref_z_r;
	cnt_type deb_r;
	logic event_r, active_r;
	logic signed [`AXIS_W:0] dx, dy, dz;
	logic [35:0] dist_sq;
	logic [35:0] ths_sq;
	logic over;
	logic event_nxt;

	// ---------------------------------------------------------------
	// distance squared against threshold squared
	// ---------------------------------------------------------------
	// zero references give absolute magnitude, else change
	always_comb begin
		dx = 17'(bus.out_x) - 17'(ref_x_r);
		dy = 17'(bus.out_y) - 17'(ref_y_r);
		dz = 17'(bus.out_z) - 17'(ref_z_r);
		dist_sq = 36'(dx * dx) + 36'(dy * dy) + 36'(dz * dz);
		ths_sq = 36'(bus.ths * bus.ths);
		over = dist_sq > ths_sq;
	end

	// ---------------------------------------------------------------
	// enable and reference handling
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r <= det_off;
			ref_x_r <= '0;
			ref_y_r <= '0;
			ref_z_r <= '0;
		end else begin
			case (state_r)
				det_off: if (bus.en) begin
					state_r <= det_on;
					if (bus.initm) begin
						ref_x_r <= bus.init_x;
						ref_y_r <= bus.init_y;
						ref_z_r <= bus.init_z;
					end else begin
						ref_x_r <= bus.out_x;
						ref_y_r <= bus.out_y;
						ref_z_r <= bus.out_z;
					end
				end
				det_on: if (!bus.en) begin
					state_r <= det_off;
				end else if (bus.initm && bus.updm) begin
					ref_x_r <= bus.init_x;
					ref_y_r <= bus.init_y;
					ref_z_r <= bus.init_z;
				end else if (event_nxt && !bus.updm) begin
					ref_x_r <= bus.out_x;
					ref_y_r <= bus.out_y;
					ref_z_r <= bus.out_z;
				end
				default: state_r <= det_off;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// debounce, evaluated once per output data cycle
	// ---------------------------------------------------------------
	assign event_nxt = (state_r == det_on) && bus.en && bus.sample_stb
		&& over && (deb_r >= bus.cnt_lim);

	always_ff @(posedge core_clk) begin
		if (rst || state_r == det_off) begin
			deb_r <= '0;
		end else if (bus.sample_stb) begin
			if (!over) begin
				deb_r <= '0;
			end else if (deb_r < bus.cnt_lim) begin
				deb_r <= deb_r + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			event_r <= 1'b0;
			active_r <= 1'b0;
		end else begin
			event_r <= event_nxt;
			if (state_r == det_off || !bus.en) begin
				active_r <= 1'b0;
			end else if (bus.sample_stb) begin
				active_r <= over && (deb_r >= bus.cnt_lim);
			end
		end
	end

	assign bus.event_stb = event_r;
	assign bus.active = active_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_event_needs_sample: assert property (@(posedge core_clk)
		disable iff (rst) event_r |-> $past(bus.sample_stb))
		else $error("event without an output data cycle");
	a_event_needs_over: assert property (@(posedge core_clk)
		disable iff (rst) event_r |-> $past(over) && $past(bus.en))
		else $error("event without distance over threshold");
	a_ref_kept_updm: assert property (@(posedge core_clk)
		disable iff (rst) (state_r == det_on && bus.en && bus.updm
		&& !bus.initm && $past(state_r) == det_on) ##1 (state_r == det_on)
		|-> $stable(ref_x_r))
		else $error("reference changed with update mode set");
	a_ref_init_load: assert property (@(posedge core_clk)
		disable iff (rst) (state_r == det_off && bus.en && bus.initm)
		|=> ref_x_r == $past(bus.init_x))
		else $error("reference not loaded from initial value");
	c_event_seen: cover property (@(posedge core_clk) event_r);
	c_event_debounced: cover property (@(posedge core_clk)
		bus.cnt_lim == 8'h02 ##0 event_r);
	c_event_update: cover property (@(posedge core_clk)
		event_r && !bus.updm);
endmodule

`default_nettype wire

// *** tb/reg_host.sv ***
// host model for the byte register port of the magnetic event block
// assumes strobes are taken on the first rising edge after they rise
`timescale 1ns/1ps
`default_nettype none

module reg_host (
	input wire logic core_clk, // shared clock
	input wire logic [7:0] reg_rdata, // read data from the block
	input wire logic reg_rvalid, // read answer pulse
	output logic [7:0] reg_addr, // register address
	output logic [7:0] reg_wdata, // write data
	output logic reg_wr, // write strobe
	output logic reg_rd // read strobe
);
	initial begin
		reg_addr = 8'hff;
		reg_wdata = 8'hff;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// released lines show the inverse of their last value
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	// the answer is registered, so it stands just after the taking edge
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge core_clk);
		#1;
		v = reg_rvalid;
		d = reg_rdata;
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask
endmodule

`default_nettype wire

// *** tb/mag_event_config_and_vecm_detect_bench.sv ***
// self-checking bench for the magnetic event block
// assumes the reg_host model and the package are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "mag_event_regs.svh"

`define CHECK(what, exp, got) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			n_fail++; \
			$display("unexpected %s exp %0h seen %0h", what, exp, got); \
		end \
	end

module mag_event_config_and_vecm_detect_bench;
	import mag_event_pkg::*;
	localparam int osr_shift [8] = '{0, 2, 3, 5, 6, 7, 8, 9};
	int n_fail = 0;
	int cmp_count = 0;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, reg_rvalid;
	logic sample_valid = 1'b0;
	axis_type raw_x = 16'h0000, raw_y = 16'h0000, raw_z = 16'h0000;
	axis_type off_x = 16'h0002, off_y = 16'hfffd, off_z = 16'h0064;
	axis_type out_x, out_y, out_z;
	logic [2:0] odr_sel = 3'h0;
	logic [`OSR_W-1:0] sleep_osr;
	logic ths_event = 1'b0;
	logic [2:0] ths_axis = 3'h0;
	logic [2:0] ths_ref_load;
	logic vecm_en = 1'b0, vecm_latch_en = 1'b0;
	logic vecm_initm = 1'b0, vecm_updm = 1'b0;
	axis_type vecm_init_x = 16'h0000, vecm_init_y = 16'h0000;
	axis_type vecm_init_z = 16'h0000;
	ths_type vecm_ths = 15'h000a;
	cnt_type vecm_cnt = 8'h02;

	always #25 core_clk = ~core_clk;

	mag_event dut_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .reg_rvalid, .sample_valid, .raw_x, .raw_y,
		.raw_z, .off_x, .off_y, .off_z, .out_x, .out_y, .out_z, .odr_sel,
		.sleep_osr, .ths_event, .ths_axis, .ths_ref_load, .vecm_en,
		.vecm_latch_en, .vecm_initm, .vecm_updm, .vecm_init_x,
		.vecm_init_y, .vecm_init_z, .vecm_ths, .vecm_cnt);

	reg_host host_u (.core_clk, .reg_rdata, .reg_rvalid, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd);

	// ----------------------------------------------------------------
	// shared steps
	// ----------------------------------------------------------------
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
		input string what);
		logic [7:0] d;
		logic v;
		host_u.read_reg(a, d, v);
		`CHECK({what, " valid"}, 1'b1, v)
		`CHECK(what, exp, d)
	endtask

	task automatic send(input axis_type x, input axis_type y,
		input axis_type z);
		tick();
		sample_valid = 1'b1;
		raw_x = x;
		raw_y = y;
		raw_z = z;
		tick();
		sample_valid = 1'b0;
		tick();
	endtask

	function automatic logic [10:0] osr_exp(input int odr, input int os);
		logic [10:0] b;
		b = (os == 0) ? 11'h010 : 11'h010 << (os - 1);
		b = b >> osr_shift[odr];
		return (b < 11'h002) ? 11'h002 : b;
	endfunction

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		rd_chk(8'h5d, 8'h00, "ctrl reset");
		rd_chk(8'h5e, 8'h00, "source reset");
		host_u.write_reg(8'h5d, 8'h5a);
		host_u.write_reg(8'h5e, 8'h07);
		host_u.write_reg(8'h40, 8'h33);
		rd_chk(8'h5d, 8'h5a, "ctrl readback");
		rd_chk(8'h5e, 8'h00, "source read only");
		rd_chk(8'h69, 8'h00, "unmapped");
		$display("register test done");
	endtask

	task automatic t_offset();
		host_u.write_reg(8'h5d, 8'h00);
		send(16'h7fff, 16'h000a, 16'hff9c);
		`CHECK("out x", 16'h8001, out_x)
		`CHECK("out y", 16'h0007, out_y)
		`CHECK("out z", 16'h0000, out_z)
		rd_chk(8'h5e, 8'h01, "new data");
		rd_chk(8'h5e, 8'h00, "no new data");
		host_u.write_reg(8'h5d, 8'h80);
		send(16'h7fff, 16'h000a, 16'hff9c);
		`CHECK("raw x", 16'h7fff, out_x)
		`CHECK("raw z", 16'hff9c, out_z)
		rd_chk(8'h5e, 8'h01, "raw new data");
		$display("offset test done");
	endtask

	task automatic t_osr();
		for (int odr = 0; odr < 8; odr++) begin
			for (int os = 0; os < 8; os++) begin
				host_u.write_reg(8'h5d, {1'b0, os[2:0], 4'h0});
				odr_sel = odr[2:0];
				tick();
				tick();
				`CHECK("sleep osr", osr_exp(odr, os), sleep_osr)
			end
		end
		$display("oversampling test done");
	endtask

	task automatic t_ths();
		for (int sel = 0; sel < 2; sel++) begin
			host_u.write_reg(8'h5d, {4'h0, sel[0], 3'h0});
			tick();
			ths_event = 1'b1;
			ths_axis = sel ? 3'b100 : 3'b010;
			tick();
			ths_event = 1'b0;
			ths_axis = 3'b000;
			`CHECK("ref load", sel ? 3'b100 : 3'b111, ths_ref_load)
			tick();
			`CHECK("ref load end", 3'b000, ths_ref_load)
			rd_chk(8'h5e, 8'h04, "threshold flag");
		end
		$display("threshold test done");
	endtask

	task automatic t_vecm_latch();
		host_u.write_reg(8'h5d, 8'h80);
		vecm_initm = 1'b1;
		vecm_updm = 1'b1;
		vecm_latch_en = 1'b1;
		vecm_en = 1'b1;
		tick();
		tick();
		for (int i = 0; i < 2; i++) begin
			send(16'h0014, 16'h0000, 16'h0000);
			rd_chk(8'h5e, 8'h01, "debounce");
		end
		send(16'h0014, 16'h0000, 16'h0000);
		send(16'h0000, 16'h0000, 16'h0000);
		rd_chk(8'h5e, 8'h03, "latched event");
		rd_chk(8'h5e, 8'h00, "cleared by read");
		$display("latched vector test done");
	endtask

	task automatic t_vecm_live();
		vecm_en = 1'b0;
		vecm_latch_en = 1'b0;
		vecm_initm = 1'b0;
		vecm_updm = 1'b0;
		send(16'h0000, 16'h0005, 16'h0000);
		vecm_en = 1'b1;
		tick();
		tick();
		repeat (3) send(16'h0000, 16'hffe7, 16'h0000);
		rd_chk(8'h5e, 8'h03, "live event");
		send(16'h0000, 16'hffe7, 16'h0000);
		rd_chk(8'h5e, 8'h01, "refs follow event");
		send(16'h0000, 16'hfff1, 16'h0000);
		rd_chk(8'h5e, 8'h01, "at threshold");
		vecm_en = 1'b0;
		vecm_initm = 1'b1;
		vecm_updm = 1'b1;
		vecm_init_z = 16'h001e;
		tick();
		vecm_en = 1'b1;
		tick();
		tick();
		repeat (3) send(16'h0000, 16'h0000, 16'h001e);
		rd_chk(8'h5e, 8'h01, "init refs");
		vecm_initm = 1'b0;
		repeat (4) send(16'h0000, 16'h0000, 16'h0000);
		rd_chk(8'h5e, 8'h03, "refs kept");
		$display("live vector test done");
	endtask

	// about 400 cycles of tests, so 6000 leaves wide margin
	initial begin
		#(50 * 6000);
		n_fail++;
		report_and_stop();
	end

	initial begin
		repeat (16) @(posedge core_clk);
		#1;
		rst = 1'b0;
		t_regs();
		t_offset();
		t_osr();
		t_ths();
		t_vecm_latch();
		t_vecm_live();
		report_and_stop();
	end
endmodule

`default_nettype wire
